/* File: smbrp_pkg.sv */
// Package for the serial register port: bank layout, strap codes and timing constants.
// Assumes a single 40 MHz system clock shared by every design file.
package smbrp_pkg;

	// ===========================================================================
	// Register bank
	localparam int          SMBRP_NUM_REGS   = 9;
	localparam logic [7:0]  SMBRP_RW_IDX_A   = 8'h05;
	localparam logic [7:0]  SMBRP_RW_IDX_B   = 8'h08;
	localparam logic [7:0]  SMBRP_RW_MASK_A  = 8'hC0;
	localparam logic [7:0]  SMBRP_RW_MASK_B  = 8'h7F;
	localparam logic [7:0]  SMBRP_REG_RESET  = 8'h00;

	// ===========================================================================
	// Address strap
	typedef enum logic [1:0] {
		SMBRP_STRAP_GND  = 2'h0,
		SMBRP_STRAP_OPEN = 2'h1,
		SMBRP_STRAP_VDD  = 2'h2
	} smbrp_strap_e;
	localparam logic [6:0]  SMBRP_ADDR_GND   = 7'h2C;
	localparam logic [6:0]  SMBRP_ADDR_OPEN  = 7'h2E;
	localparam logic [6:0]  SMBRP_ADDR_VDD   = 7'h2F;

	// ===========================================================================
	// Timing
	localparam int          SMBRP_CLK_MHZ    = 40;
	localparam int          SMBRP_TDV_NS     = 200;
	localparam int          SMBRP_TDV_CYC    = (SMBRP_TDV_NS * SMBRP_CLK_MHZ + 999) / 1000;

endpackage : smbrp_pkg

/* File: smbrp_bank.sv */
// Register bank: nine byte registers, status loaded from internal logic, two host-writable.
// Assumes write strobes come from the serial engine on the same clock.
module smbrp_bank
	import smbrp_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	input  wire logic [8*SMBRP_NUM_REGS-1:0] status_in,
	input  wire logic                    wr_en,
	input  wire logic [7:0]              wr_idx,
	input  wire logic [7:0]              wr_data,
	input  wire logic [7:0]              rd_idx,
	output logic      [7:0]              rd_data,
	output logic      [7:0]              ctrl_a,
	output logic      [7:0]              ctrl_b
);
	logic [7:0] regs_r [SMBRP_NUM_REGS];

	// ===========================================================================
	// Storage
	genvar g;
	generate
		for (g = 0; g < SMBRP_NUM_REGS; g++) begin : g_reg
			localparam logic [7:0] IDX = 8'(g);
			localparam logic [7:0] WM  = (IDX == SMBRP_RW_IDX_A) ? SMBRP_RW_MASK_A :
				(IDX == SMBRP_RW_IDX_B) ? SMBRP_RW_MASK_B : 8'h00;
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					regs_r[g] <= SMBRP_REG_RESET;
				end else if (wr_en && wr_idx == IDX) begin
					// Only writable bits change; status bits keep following the core.
					regs_r[g] <= (wr_data & WM) | (status_in[8*g +: 8] & ~WM);
				end else begin
					regs_r[g] <= (regs_r[g] & WM) | (status_in[8*g +: 8] & ~WM);
				end
			end
		end
	endgenerate

	// Unmapped indices read as zero.
	assign rd_data = (rd_idx < 8'(SMBRP_NUM_REGS)) ? regs_r[rd_idx[3:0]] : 8'h00;
	assign ctrl_a  = regs_r[SMBRP_RW_IDX_A[3:0]];
	assign ctrl_b  = regs_r[SMBRP_RW_IDX_B[3:0]];

endmodule : smbrp_bank

/* File: smbrp_top.sv */
// Two-wire slave port giving a host access to a nine-byte register bank.
// Assumes scl and sda come from pins asynchronous to ref_clk and are synchronised here.
// Functional notes
// - Exactly nine registers are reachable through the serial slave port.
// - Every register is one byte; each data transfer is eight bits.
// - Reserved bits reset to zero and read back as zero.
// - Two registers are read/write; seven are read-only status from internal logic.
// - The port is only a slave; the host starts every transaction.
// - Strap selects address: ground 0101100, open 0101110, supply 0101111.
// - First byte holds address in upper seven bits, direction in bit zero.
// - Strap sampled once after reset; mismatched address ignored until next start.
// - Send, receive, read and write byte or word; command byte selects register.
// - Host writes to read-only registers leave their contents unchanged.
module smbrp_top
	import smbrp_pkg::*;
(
	input  wire logic                        ref_clk,
	input  wire logic                        reset,
	input  wire smbrp_pkg::smbrp_strap_e     addr_strap,
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe_n,
	input  wire logic [8*smbrp_pkg::SMBRP_NUM_REGS-1:0] status_in,
	output logic      [7:0]                  ctrl_a,
	output logic      [7:0]                  ctrl_b,
	output logic      [6:0]                  own_addr
);
	import smbrp_pkg::*;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK  = 6'h04,
		ST_RX   = 6'h08,
		ST_TX   = 6'h10,
		ST_MACK = 6'h20
	} smbrp_state_e;

	// ===========================================================================
	// Synchronisers
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic       scl_d_r;
	logic       sda_d_r;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl_in};
			sda_sync_r <= {sda_sync_r[0], sda_in};
			scl_d_r    <= scl_sync_r[1];
			sda_d_r    <= sda_sync_r[1];
		end
	end
	wire scl_s   = scl_sync_r[1];
	wire sda_s   = sda_sync_r[1];
	wire scl_ris = scl_s && !scl_d_r;
	wire scl_fal = !scl_s && scl_d_r;
	wire start_c = scl_s && scl_d_r && !sda_s && sda_d_r;
	wire stop_c  = scl_s && scl_d_r && sda_s && !sda_d_r;

	// ===========================================================================
	// Address strap, caught once after reset release
	logic strap_done_r;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			strap_done_r <= 1'b0;
			own_addr     <= SMBRP_ADDR_OPEN;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			case (addr_strap)
				SMBRP_STRAP_GND: begin
					own_addr <= SMBRP_ADDR_GND;
				end
				SMBRP_STRAP_VDD: begin
					own_addr <= SMBRP_ADDR_VDD;
				end
				default: begin
					own_addr <= SMBRP_ADDR_OPEN;
				end
			endcase
		end
	end

	// ===========================================================================
	// Byte engine
	smbrp_state_e state_r;
	logic [7:0]   shift_r;
	logic [2:0]   bit_r;
	logic         rnw_r;
	logic         first_r;
	logic         cmd_seen_r;
	logic [7:0]   idx_r;
	logic         ack_r;
	logic         wr_en_r;
	logic [7:0]   wr_data_r;
	logic [7:0]   wr_idx_r;
	logic [7:0]   rd_data;
	logic [7:0]   tdv_cnt_r;
	logic         tx_bit_r;
	logic         drive_r;

	always_ff @(posedge ref_clk) begin
		wr_en_r <= 1'b0;
		if (reset) begin
			state_r    <= ST_IDLE;
			shift_r    <= 8'h00;
			bit_r      <= 3'h0;
			rnw_r      <= 1'b0;
			first_r    <= 1'b0;
			cmd_seen_r <= 1'b0;
			idx_r      <= 8'h00;
			ack_r      <= 1'b0;
			wr_data_r  <= 8'h00;
			wr_idx_r   <= 8'h00;
		end else if (start_c) begin
			state_r    <= ST_ADDR;
			bit_r      <= 3'h0;
			// Holding this keeps the start's own falling clock from closing an empty byte.
			ack_r      <= 1'b1;
			cmd_seen_r <= 1'b0;
		end else if (stop_c) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_ADDR, ST_RX: begin
					if (scl_ris) begin
						shift_r <= {shift_r[6:0], sda_s};
						bit_r   <= bit_r + 3'h1;
					end else if (scl_fal && bit_r == 3'h0 && ack_r == 1'b0) begin
						ack_r <= 1'b1;
						if (state_r == ST_ADDR) begin
							// A foreign address parks the engine until the next start.
							if (shift_r[7:1] == own_addr) begin
								rnw_r   <= shift_r[0];
								first_r <= 1'b1;
								state_r <= ST_ACK;
							end else begin
								state_r <= ST_IDLE;
							end
						end else begin
							state_r <= ST_ACK;
							if (!cmd_seen_r) begin
								idx_r      <= shift_r;
								cmd_seen_r <= 1'b1;
							end else begin
								wr_en_r   <= 1'b1;
								wr_data_r <= shift_r;
								wr_idx_r  <= idx_r;
								idx_r     <= idx_r + 8'h01;
							end
						end
					end else if (scl_ris || bit_r != 3'h0) begin
						ack_r <= 1'b0;
					end
				end
				ST_ACK: begin
					if (scl_fal) begin
						ack_r <= 1'b0;
						bit_r <= 3'h0;
						if (first_r && rnw_r) begin
							shift_r <= rd_data;
							state_r <= ST_TX;
						end else if (!first_r && rnw_r) begin
							state_r <= ST_TX;
						end else begin
							state_r <= ST_RX;
						end
						first_r <= 1'b0;
					end
				end
				ST_TX: begin
					if (scl_fal) begin
						shift_r <= {shift_r[6:0], 1'b0};
						bit_r   <= bit_r + 3'h1;
						if (bit_r == 3'h7) begin
							state_r <= ST_MACK;
						end
					end
				end
				ST_MACK: begin
					if (scl_ris && sda_s) begin
						state_r <= ST_IDLE;
					end else if (scl_ris) begin
						idx_r <= idx_r + 8'h01;
					end else if (scl_fal) begin
						state_r <= ST_TX;
						shift_r <= rd_data;
						bit_r   <= 3'h0;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ===========================================================================
	// Data line drive, delayed after each falling clock to respect data hold.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tdv_cnt_r <= 8'h00;
			tx_bit_r  <= 1'b1;
			drive_r   <= 1'b0;
		end else if (scl_fal) begin
			tdv_cnt_r <= 8'(SMBRP_TDV_CYC);
		end else if (tdv_cnt_r != 8'h00) begin
			tdv_cnt_r <= tdv_cnt_r - 8'h01;
		end else begin
			drive_r  <= (state_r == ST_ACK) || (state_r == ST_TX && !shift_r[7]);
			tx_bit_r <= 1'b0;
		end
	end
	assign sda_out  = tx_bit_r;
	assign sda_oe_n = !drive_r || (state_r == ST_IDLE);

	smbrp_bank u_bank (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.status_in (status_in),
		.wr_en     (wr_en_r),
		.wr_idx    (wr_idx_r),
		.wr_data   (wr_data_r),
		.rd_idx    (idx_r),
		.rd_data   (rd_data),
		.ctrl_a    (ctrl_a),
		.ctrl_b    (ctrl_b)
	);

	// ===========================================================================
	// Checks
	sequence s_addr_fail;
		state_r == ST_ADDR && scl_fal && bit_r == 3'h0 && !ack_r && shift_r[7:1] != own_addr;
	endsequence
	sequence s_ack_hold;
		sda_oe_n [*8] ##2 !sda_oe_n;
	endsequence
	chk_idle_released: assert property (@(posedge ref_clk) disable iff (reset)
		(state_r == ST_IDLE || state_r == ST_ADDR) |-> sda_oe_n)
		else $error("Data line driven outside a transfer.");
	chk_nomatch_idle: assert property (@(posedge ref_clk) disable iff (reset)
		s_addr_fail ##1 !start_c [*2] |-> state_r == ST_IDLE)
		else $error("Foreign address not ignored.");
	chk_strap_once: assert property (@(posedge ref_clk) disable iff (reset)
		strap_done_r |=> $stable(own_addr))
		else $error("Own address changed.");
	chk_strap_gnd: assert property (@(posedge ref_clk) disable iff (reset)
		!strap_done_r && addr_strap == SMBRP_STRAP_GND |=> own_addr == 7'h2C)
		else $error("Ground strap address wrong.");
	chk_ro_write: assert property (@(posedge ref_clk) disable iff (reset)
		wr_en_r && wr_idx_r == SMBRP_RW_IDX_B |=> (ctrl_b & ~SMBRP_RW_MASK_B) ==
		($past(status_in[8*SMBRP_RW_IDX_B +: 8]) & ~SMBRP_RW_MASK_B))
		else $error("Read-only bit took host data.");
	chk_rw_write: assert property (@(posedge ref_clk) disable iff (reset)
		wr_en_r && wr_idx_r == SMBRP_RW_IDX_A |=> (ctrl_a & SMBRP_RW_MASK_A) ==
		($past(wr_data_r) & SMBRP_RW_MASK_A))
		else $error("Writable bits not stored.");
	chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (reset)
		idx_r >= 8'h09 |-> rd_data == 8'h00)
		else $error("Unmapped index not zero.");
	chk_ack_timing: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(state_r == ST_ACK) |-> s_ack_hold)
		else $error("Acknowledge drive not after the hold delay.");
	chk_reset_regs: assert property (@(posedge ref_clk)
		reset |=> ctrl_b == 8'h00)
		else $error("Control not reset to zero.");

endmodule : smbrp_top

/* File: smbrp_host_model.sv */
// Host master model for the two-wire port: open-drain data, clock held high between frames.
// Assumes a pulled-up data line and a caller that supplies the system clock.
module smbrp_host_model (
	input  wire logic ref_clk,
	input  wire logic sda_out,
	input  wire logic sda_oe_n,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 100ps;
	// Half bit of 5 us gives 100 kHz with both clock phases above their minimum widths.
	localparam int HALF = 200;
	logic host_low = 1'b0;
	initial scl = 1'b1;
	// Either party may only pull low; a released line floats up to one.
	assign sda = !(host_low || (!sda_oe_n && !sda_out));

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	// Data moves only while the clock is low, well past the falling edge.
	task automatic put_bit(input logic b, output logic r);
		tick(10);
		host_low = !b;
		tick(HALF - 10);
		scl = 1'b1;
		tick(HALF / 2);
		r = sda;
		tick(HALF / 2);
		scl = 1'b0;
	endtask : put_bit

	task automatic start();
		if (scl === 1'b0) begin
			tick(10);
			host_low = 1'b0;
			tick(HALF);
			scl = 1'b1;
			tick(HALF);
		end
		host_low = 1'b1;
		tick(HALF);
		scl = 1'b0;
	endtask : start

	task automatic stop();
		tick(10);
		host_low = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		host_low = 1'b0;
		tick(HALF);
	endtask : stop

	task automatic write_byte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) put_bit(v[i], r);
		put_bit(1'b1, r);
		ack = !r;
	endtask : write_byte

	task automatic read_byte(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, r);
			v[i] = r;
		end
		put_bit(last, r);
	endtask : read_byte
endmodule : smbrp_host_model

/* File: smbrp_top_tb.sv */
// Self-checking bench for the two-wire register port.
// Assumes the host model in smbrp_host_model.sv and a pulled-up data line.
module smbrp_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import smbrp_pkg::*;
	logic                           ref_clk = 1'b0;
	logic                           reset = 1'b1;
	smbrp_strap_e                   addr_strap = SMBRP_STRAP_OPEN;
	logic [8*SMBRP_NUM_REGS-1:0]    status_in = 72'h99_88_77_66_55_44_33_22_11;
	logic                           scl;
	logic                           sda;
	logic                           sda_out;
	logic                           sda_oe_n;
	logic [7:0]                     ctrl_a;
	logic [7:0]                     ctrl_b;
	logic [6:0]                     own_addr;
	logic                           watch = 1'b0;
	logic                           drove = 1'b0;
	int                             errors = 0;
	int                             samples_checked = 0;

	always #12.5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (watch && sda_oe_n !== 1'b1) drove = 1'b1;

	smbrp_top i_smbrp_top (.ref_clk(ref_clk), .reset(reset), .addr_strap(addr_strap),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.status_in(status_in), .ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .own_addr(own_addr));
	smbrp_host_model i_smbrp_host_model (.ref_clk(ref_clk), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp8

	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task automatic wr(input logic [6:0] a, input logic [7:0] idx, d0, d1, input int n,
		input logic ex);
		logic ak;
		logic [7:0] b [4];
		b = '{{a, 1'b0}, idx, d0, d1};
		i_smbrp_host_model.start();
		for (int i = 0; i < n + 2; i++) begin
			i_smbrp_host_model.write_byte(b[i], ak);
			cmp8({7'h00, ak}, {7'h00, ex}, "write ack");
		end
		i_smbrp_host_model.stop();
	endtask : wr

	// Reads up to three bytes; the first expected byte sits in the top of e.
	task automatic rd(input logic [7:0] idx, input logic cmd, input int n, input logic [23:0] e);
		logic ak;
		logic [7:0] v;
		i_smbrp_host_model.start();
		if (cmd) begin
			i_smbrp_host_model.write_byte({7'h2E, 1'b0}, ak);
			i_smbrp_host_model.write_byte(idx, ak);
			i_smbrp_host_model.start();
		end
		i_smbrp_host_model.write_byte({7'h2E, 1'b1}, ak);
		cmp8({7'h00, ak}, 8'h01, "read address ack");
		for (int i = 0; i < n; i++) begin
			i_smbrp_host_model.read_byte(i == n - 1, v);
			cmp8(v, e[23 - 8 * i -: 8], "read data");
		end
		i_smbrp_host_model.stop();
	endtask : rd

	task automatic t_strap();
		smbrp_strap_e s [3] = '{SMBRP_STRAP_GND, SMBRP_STRAP_VDD, SMBRP_STRAP_OPEN};
		logic [6:0] e [3] = '{7'h2C, 7'h2F, 7'h2E};
		for (int i = 0; i < 3; i++) begin
			@(negedge ref_clk);
			addr_strap = s[i];
			reset = 1'b1;
			repeat (20) @(negedge ref_clk);
			reset = 1'b0;
			repeat (12) @(negedge ref_clk);
			// The strap moving after power-up must not move the address.
			addr_strap = SMBRP_STRAP_GND;
			repeat (4) @(negedge ref_clk);
			cmp8({1'b0, own_addr}, {1'b0, e[i]}, "strap address");
		end
		$display("strap test done, mismatches %0d", errors);
	endtask : t_strap

	task automatic t_write();
		wr(7'h2E, 8'h05, 8'hFF, 8'h00, 1, 1'b1);
		cmp8(ctrl_a, 8'hE6, "register 05");
		wr(7'h2E, 8'h07, 8'h11, 8'h2A, 2, 1'b1);
		cmp8(ctrl_b, 8'hAA, "register 08");
		wr(7'h2E, 8'h03, 8'hFF, 8'h00, 1, 1'b1);
		rd(8'h03, 1'b1, 3, 24'h44_55_E6);
		rd(8'h08, 1'b1, 2, 24'hAA_00_00);
		$display("write and read test done, mismatches %0d", errors);
	endtask : t_write

	task automatic t_send();
		wr(7'h2E, 8'h06, 8'h00, 8'h00, 0, 1'b1);
		rd(8'h00, 1'b0, 1, 24'h77_00_00);
		$display("send and receive test done, mismatches %0d", errors);
	endtask : t_send

	task automatic t_foreign();
		watch = 1'b1;
		wr(7'h2D, 8'h05, 8'h00, 8'h00, 1, 1'b0);
		watch = 1'b0;
		cmp8({7'h00, drove}, 8'h00, "data line driven");
		cmp8(ctrl_a, 8'hE6, "register 05 kept");
		$display("foreign address test done, mismatches %0d", errors);
	endtask : t_foreign

	initial begin
		t_strap();
		t_write();
		t_send();
		t_foreign();
		close_out();
	end

	// Every transfer is a fixed count of bit times, so one bound covers the run.
	initial begin
		repeat (120000) @(posedge ref_clk);
		$display("unexpected at %0t ns: run timed out", $time);
		errors++;
		close_out();
	end
endmodule : smbrp_top_tb
